// File: hdl/wtw_pkg.sv
// package of register map, field layouts and timing constants for the time-wheel watchdog
// Behaviour
// - once enabled, watchdog stays on until reset
// - count increments at each selected wheel period
// - timeout falls between two and three periods
// - period codes mean 2,16,128,1024 ticks
// - low-power codes keep, longest period, stop
// - start sets period, clears wheel, lowpower, enable
// - settings writes ignored once enabled
// - feed clears the watchdog count
// - reset cause holds five flags, two general bits
package wtw_pkg;
    // register byte offsets
    localparam logic [11:0] WTW_CTRL_OFF = 12'h000;
    localparam logic [11:0] WTW_FEED_OFF = 12'h004;
    localparam logic [11:0] WTW_STAT_OFF = 12'h008;
    localparam logic [11:0] WTW_CAUSE_OFF = 12'h00C;
    localparam logic [11:0] WTW_IRQ_STAT_OFF = 12'h010;
    localparam logic [11:0] WTW_IRQ_MASK_OFF = 12'h014;
    // control register fields
    localparam int WTW_CTRL_PER_LSB = 0;
    localparam int WTW_CTRL_LP_LSB = 2;
    localparam int WTW_CTRL_EN_BIT = 4;
    localparam int WTW_CTRL_WCLR_BIT = 5;
    // feed register key, write of this value feeds
    localparam logic [31:0] WTW_FEED_KEY = 32'h0000_0001;
    // reset cause bit positions
    localparam int WTW_CAUSE_LVID = 0;
    localparam int WTW_CAUSE_LVIA = 1;
    localparam int WTW_CAUSE_HVIA = 2;
    localparam int WTW_CAUSE_WD = 3;
    localparam int WTW_CAUSE_SW = 4;
    localparam int WTW_CAUSE_GP0 = 5;
    localparam int WTW_CAUSE_GP1 = 6;
    // interrupt status bits
    localparam int WTW_IRQ_PERIOD = 0;
    localparam int WTW_IRQ_BITE = 1;
    // period and low-power encodings
    localparam logic [1:0] WTW_PER_TWO = 2'h0;
    localparam logic [1:0] WTW_PER_16 = 2'h1;
    localparam logic [1:0] WTW_PER_128 = 2'h2;
    localparam logic [1:0] WTW_PER_1024 = 2'h3;
    localparam logic [1:0] WTW_LP_KEEP = 2'h0;
    localparam logic [1:0] WTW_LP_LONGEST = 2'h1;
    localparam logic [1:0] WTW_LP_STOP = 2'h3;
    // wheel and count widths, bite threshold
    localparam int WTW_WHEEL_W = 10;
    localparam logic [1:0] WTW_BITE_COUNT = 2'h3;
    localparam logic [9:0] WTW_WHEEL_RST = 10'h000;
    // reset pulse length in cycles
    localparam logic [3:0] WTW_BITE_LEN = 4'hF;
endpackage : wtw_pkg

// File: hdl/wtw_sync.sv
// two flip-flop synchroniser for level inputs from pins
`timescale 1ns/100ps
module wtw_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // state: first and second stage
    typedef struct packed {
        logic [W-1:0] s1_reg;
        logic [W-1:0] s2_reg;
    } wtw_sync_s;
    wtw_sync_s st_reg;
    wtw_sync_s st_next;

    // next: shift one stage
    always_comb begin
        st_next.s1_reg = din;
        st_next.s2_reg = st_reg.s1_reg;
    end

    // register with async reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.s2_reg;
endmodule : wtw_sync

// File: hdl/wtw_wheel.sv
// free-running central time wheel with period taps
`timescale 1ns/100ps
module wtw_wheel
    import wtw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic wheel_clear,
    input wire logic [1:0] period_sel,
    output logic period_hit
);
    // state: wheel counter and hit flag
    typedef struct packed {
        logic [WTW_WHEEL_W-1:0] wheel_reg;
        logic hit_reg;
    } wtw_wheel_s;
    wtw_wheel_s st_reg;
    wtw_wheel_s st_next;
    logic [WTW_WHEEL_W-1:0] wheel_inc;
    logic [WTW_WHEEL_W-1:0] mask;

    // mask for period: 2,16,128,1024 ticks
    always_comb begin
        case (period_sel)
            WTW_PER_TWO: mask = 10'h001;
            WTW_PER_16: mask = 10'h00F;
            WTW_PER_128: mask = 10'h07F;
            default: mask = 10'h3FF;
        endcase
    end

    assign wheel_inc = st_reg.wheel_reg + 10'h001;

    // next: free-running wheel, pulse on period boundary
    always_comb begin
        st_next = st_reg;
        st_next.hit_reg = 1'b0;
        if (wheel_clear) begin
            st_next.wheel_reg = WTW_WHEEL_RST;
        end else if (tick) begin
            st_next.wheel_reg = wheel_inc;
            st_next.hit_reg = ((wheel_inc & mask) == 10'h000);
        end
    end

    // register with async reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign period_hit = st_reg.hit_reg;
endmodule : wtw_wheel

// File: hdl/wtw_top.sv
// watchdog on the central time wheel with apb registers and reset cause
`timescale 1ns/100ps
module wtw_top
    import wtw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wheel_tick,
    input wire logic low_power_active,
    input wire logic [4:0] reset_event,
    output logic wdt_reset,
    output logic irq
);
    // pin inputs: wheel tick, sleep state, reset events
    logic [6:0] pin_sync;
    logic tick_s;
    logic sleep_s;
    logic [4:0] event_s;
    // period pulse from the wheel
    logic period_hit;
    // register state of the block
    typedef struct packed {
        logic en_reg;             // locked enable
        logic [1:0] per_reg;      // period selection
        logic [1:0] lp_reg;       // low power behaviour
        logic [1:0] count_reg;    // expirations since feed
        logic [6:0] cause_reg;    // reset cause status
        logic [1:0] istat_reg;    // sticky interrupt status
        logic [1:0] imask_reg;    // interrupt mask
        logic [3:0] bite_reg;     // reset pulse counter
        logic tick_d_reg;         // tick edge history
        logic wclr_reg;           // wheel clear pulse
        logic [31:0] prdata_reg;  // read data
        logic pready_reg;         // access acknowledge
        logic pslverr_reg;        // unmapped answer
        logic reset_reg;          // system reset out
        logic irq_reg;            // interrupt out
    } wtw_top_s;
    wtw_top_s st_reg;
    wtw_top_s st_next;
    // bus decode helpers
    logic acc_wr;             // write lands on the completing edge
    logic acc_rd;             // read data captured in first access cycle
    logic mapped;
    logic feed;
    logic [1:0] eff_per;
    logic run;

    // synchronise the pin inputs
    wtw_sync #(
        .W(7)
    ) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .din({reset_event, low_power_active, wheel_tick}),
        .dout(pin_sync)
    );
    assign tick_s = pin_sync[0];
    assign sleep_s = pin_sync[1];
    assign event_s = pin_sync[6:2];

    // effective period: longest in sleep if chosen
    always_comb begin
        if (sleep_s && st_reg.lp_reg == WTW_LP_LONGEST) begin
            eff_per = WTW_PER_1024;
        end else begin
            eff_per = st_reg.per_reg;
        end
    end
    // counting halted in sleep when stop is chosen
    assign run = st_reg.en_reg && !(sleep_s && st_reg.lp_reg == WTW_LP_STOP);

    // the central time wheel
    wtw_wheel u_wheel (
        .core_clk(core_clk),
        .rstn(rstn),
        .tick(tick_s && !st_reg.tick_d_reg),
        .wheel_clear(st_reg.wclr_reg),
        .period_sel(eff_per),
        .period_hit(period_hit)
    );

    // apb: one wait state; a write lands only on the edge that sees pready high
    assign acc_wr = psel && penable && pwrite && st_reg.pready_reg;
    assign acc_rd = psel && penable && !pwrite && !st_reg.pready_reg;
    assign mapped = (paddr == WTW_CTRL_OFF) || (paddr == WTW_FEED_OFF) || (paddr == WTW_STAT_OFF)
        || (paddr == WTW_CAUSE_OFF) || (paddr == WTW_IRQ_STAT_OFF) || (paddr == WTW_IRQ_MASK_OFF);
    assign feed = acc_wr && paddr == WTW_FEED_OFF && pwdata == WTW_FEED_KEY;

    // next-state logic of the whole block
    always_comb begin
        st_next = st_reg;
        st_next.tick_d_reg = tick_s;
        st_next.wclr_reg = 1'b0;
        st_next.pready_reg = 1'b0;
        st_next.pslverr_reg = 1'b0;
        // hardware reset events latch into the cause
        st_next.cause_reg[4:0] = st_reg.cause_reg[4:0] | event_s;
        // control write only while unlocked
        if (acc_wr && paddr == WTW_CTRL_OFF && !st_reg.en_reg) begin
            st_next.per_reg = pwdata[WTW_CTRL_PER_LSB +: 2];
            st_next.lp_reg = pwdata[WTW_CTRL_LP_LSB +: 2];
            st_next.wclr_reg = pwdata[WTW_CTRL_WCLR_BIT];
            st_next.en_reg = pwdata[WTW_CTRL_EN_BIT];
            st_next.count_reg = 2'h0;
        end
        // period expirations count up while running
        if (run && period_hit && st_reg.count_reg != WTW_BITE_COUNT) begin
            st_next.count_reg = st_reg.count_reg + 2'h1;
            st_next.istat_reg[WTW_IRQ_PERIOD] = 1'b1;
        end
        // feed restarts counting from zero; wheel keeps running, so timeout is two to three periods
        if (feed && st_reg.en_reg) begin
            st_next.count_reg = 2'h0;
        end
        // reset cause: write one clears, general bits writable
        if (acc_wr && paddr == WTW_CAUSE_OFF) begin
            st_next.cause_reg[4:0] = (st_reg.cause_reg[4:0] & ~pwdata[4:0]) | event_s;
            st_next.cause_reg[6:5] = pwdata[6:5];
        end
        // interrupt status write one to clear
        if (acc_wr && paddr == WTW_IRQ_STAT_OFF) begin
            st_next.istat_reg = st_reg.istat_reg & ~pwdata[1:0];
        end
        if (acc_wr && paddr == WTW_IRQ_MASK_OFF) begin
            st_next.imask_reg = pwdata[1:0];
        end
        // re-set wins over software clear
        if (run && period_hit) begin
            st_next.istat_reg[WTW_IRQ_PERIOD] = 1'b1;
        end
        // count reached three: bite
        if (st_reg.count_reg == WTW_BITE_COUNT && st_reg.bite_reg == 4'h0) begin
            st_next.bite_reg = WTW_BITE_LEN;
            st_next.cause_reg[WTW_CAUSE_WD] = 1'b1;
            st_next.istat_reg[WTW_IRQ_BITE] = 1'b1;
            st_next.count_reg = 2'h0;
        end else if (st_reg.bite_reg != 4'h0) begin
            st_next.bite_reg = st_reg.bite_reg - 4'h1;
        end
        st_next.reset_reg = (st_next.bite_reg != 4'h0);
        // read data
        st_next.prdata_reg = 32'h0000_0000;
        if (acc_rd) begin
            case (paddr)
                WTW_CTRL_OFF: st_next.prdata_reg = {27'h0, st_reg.en_reg, st_reg.lp_reg, st_reg.per_reg};
                WTW_STAT_OFF: st_next.prdata_reg = {30'h0, st_reg.count_reg};
                WTW_CAUSE_OFF: st_next.prdata_reg = {25'h0, st_reg.cause_reg};
                WTW_IRQ_STAT_OFF: st_next.prdata_reg = {30'h0, st_reg.istat_reg};
                WTW_IRQ_MASK_OFF: st_next.prdata_reg = {30'h0, st_reg.imask_reg};
                default: st_next.prdata_reg = 32'h0000_0000;
            endcase
        end
        // answer after one access cycle, for one cycle only
        if (psel && penable && !st_reg.pready_reg) begin
            st_next.pready_reg = 1'b1;
            st_next.pslverr_reg = !mapped;
        end
        st_next.irq_reg = |(st_next.istat_reg & st_next.imask_reg);
    end

    // state register; reset unlocks and clears
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata_reg;
    assign pready = st_reg.pready_reg;
    assign pslverr = st_reg.pslverr_reg;
    assign wdt_reset = st_reg.reset_reg;
    assign irq = st_reg.irq_reg;

    // enable never falls without reset
    lock_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_reg.en_reg |=> st_reg.en_reg) else $error("watchdog enable dropped");
    // settings frozen while enabled
    settings_frozen_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_reg.en_reg |=> $stable(st_reg.per_reg) && $stable(st_reg.lp_reg)) else $error("settings changed");
    // feed zeroes the count
    feed_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
        feed && st_reg.en_reg && st_reg.count_reg != WTW_BITE_COUNT |=> st_reg.count_reg == 2'h0)
        else $error("feed did not clear count");
    // count three gives reset and cause flag
    bite_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_reg.count_reg == WTW_BITE_COUNT && st_reg.bite_reg == 4'h0 |=> ##1 wdt_reset && st_reg.cause_reg[WTW_CAUSE_WD])
        else $error("no reset on bite");
    // count advances only on a period hit
    count_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_reg.count_reg != $past(st_reg.count_reg) && st_reg.count_reg != 2'h0 |-> $past(period_hit) && $past(run))
        else $error("count moved without period");
    // stopped in sleep means no counting
    sleep_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
        sleep_s && st_reg.lp_reg == WTW_LP_STOP && st_reg.count_reg == 2'h1 |=> st_reg.count_reg != 2'h2)
        else $error("counted while stopped");
    // cause write one clears a flag absent new event
    cause_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        acc_wr && paddr == WTW_CAUSE_OFF && pwdata[WTW_CAUSE_SW] && !event_s[WTW_CAUSE_SW]
        |=> !st_reg.cause_reg[WTW_CAUSE_SW]) else $error("cause not cleared");
    // period hit marks the sticky status
    period_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn)
        run && period_hit |=> st_reg.istat_reg[WTW_IRQ_PERIOD]) else $error("period status missed");
endmodule : wtw_top

// File: verification/test_watchdog_with_time_wheel.sv
// self-checking bench for the time-wheel watchdog
`timescale 1ns/100ps
module test_watchdog_with_time_wheel
    import wtw_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdt_reset;
    logic irq;
    logic wheel_tick = 1'b0;
    logic low_power_active = 1'b0;
    logic [4:0] reset_event = 5'h00;
    int num_errors = 0;
    int checked = 0;
    int bite_len = 0; // cycles seen with reset request high
    logic [31:0] rd; // last read data
    logic err; // last slave error
    // ordinary cases: {error, write, address, write data or expected read data}
    localparam logic [45:0] ROWS [10] = '{
        {1'b0, 1'b0, WTW_CTRL_OFF, 32'h0000_0000},
        {1'b0, 1'b0, WTW_STAT_OFF, 32'h0000_0000},
        {1'b0, 1'b1, WTW_CAUSE_OFF, 32'h0000_0060},
        {1'b0, 1'b0, WTW_CAUSE_OFF, 32'h0000_0060},
        {1'b0, 1'b1, WTW_CAUSE_OFF, 32'h0000_0000},
        {1'b0, 1'b0, WTW_CAUSE_OFF, 32'h0000_0000},
        {1'b0, 1'b1, WTW_CTRL_OFF, 32'h0000_0030},
        {1'b0, 1'b1, WTW_CTRL_OFF, 32'h0000_000E},
        {1'b0, 1'b0, WTW_CTRL_OFF, 32'h0000_0010},
        {1'b1, 1'b0, 12'h020, 32'h0000_0000}
    };

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // length of each reset request pulse
    always @(posedge core_clk) begin
        if (wdt_reset === 1'b1) begin
            bite_len <= bite_len + 1;
        end
    end

    wtw_top dut_u (
        .core_clk(core_clk),
        .rstn(rstn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wheel_tick(wheel_tick),
        .low_power_active(low_power_active),
        .reset_event(reset_event),
        .wdt_reset(wdt_reset),
        .irq(irq)
    );

    // counts and verdict, then stop
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // one comparison
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[ERR] pready expected 1 seen %b", pready);
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // wheel ticks, wide enough for the synchroniser
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge core_clk);
            wheel_tick <= 1'b1;
            repeat (3) @(posedge core_clk);
            wheel_tick <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask : ticks

    // main sequence
    initial begin
        int n;
        int per_ticks;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        foreach (ROWS[i]) begin
            apb(ROWS[i][44], ROWS[i][43:32], ROWS[i][31:0]);
            if (!ROWS[i][44]) begin
                chk("read data", ROWS[i][31:0], rd);
                chk("slave error", {31'h0, ROWS[i][45]}, {31'h0, err});
            end
        end
        $display("table cases done");
        // period of two ticks, feed, then bite
        ticks(2);
        apb(1'b0, WTW_STAT_OFF, 32'h0);
        chk("count one period", 32'h1, rd);
        apb(1'b1, WTW_FEED_OFF, WTW_FEED_KEY);
        apb(1'b0, WTW_STAT_OFF, 32'h0);
        chk("count after feed", 32'h0, rd);
        apb(1'b1, WTW_IRQ_MASK_OFF, 32'h0000_0002);
        bite_len = 0;
        ticks(4);
        chk("no bite in two periods", 32'h0, bite_len);
        ticks(2);
        n = 0;
        while (!(bite_len != 0 && wdt_reset === 1'b0) && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            $display("[ERR] reset pulse end expected within 100 cycles seen none");
            end_sim();
        end
        chk("bite length", {28'h0, WTW_BITE_LEN}, bite_len);
        chk("irq on bite", 32'h1, {31'h0, irq});
        apb(1'b0, WTW_CAUSE_OFF, 32'h0);
        chk("watchdog cause", 32'h0000_0008, rd);
        $display("bite test done");
        // software cause latched and cleared, interrupt cleared
        reset_event <= 5'h10;
        repeat (4) @(posedge core_clk);
        reset_event <= 5'h00;
        apb(1'b0, WTW_CAUSE_OFF, 32'h0);
        chk("software cause", 32'h0000_0018, rd);
        apb(1'b1, WTW_CAUSE_OFF, 32'h0000_0018);
        apb(1'b0, WTW_CAUSE_OFF, 32'h0);
        chk("cause cleared", 32'h0, rd);
        apb(1'b1, WTW_IRQ_STAT_OFF, 32'h0000_0003);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("cause test done");
        // low-power codes longest and stop, each after a mid-run reset
        foreach (ROWS[i]) begin
            if (i < 2) begin
                @(posedge core_clk);
                rstn <= 1'b0;
                repeat (3) @(posedge core_clk);
                rstn <= 1'b1;
                apb(1'b0, WTW_STAT_OFF, 32'h0);
                chk("count after reset", 32'h0, rd);
                apb(1'b1, WTW_CTRL_OFF, {26'h0, 2'h3, i ? WTW_LP_STOP : WTW_LP_LONGEST, WTW_PER_TWO});
                apb(1'b0, WTW_CTRL_OFF, 32'h0);
                chk("ctrl reconfigured", {27'h0, 1'b1, i ? WTW_LP_STOP : WTW_LP_LONGEST, 2'h0}, rd);
                ticks(2);
                low_power_active <= 1'b1;
                bite_len = 0;
                ticks(8);
                apb(1'b0, WTW_STAT_OFF, 32'h0);
                chk("count in sleep", 32'h1, rd);
                chk("no bite in sleep", 32'h0, bite_len);
                low_power_active <= 1'b0;
                ticks(2);
                apb(1'b0, WTW_STAT_OFF, 32'h0);
                chk("count after wake", 32'h2, rd);
            end
        end
        $display("low power test done");
        // period codes 16, 128 and 1024 ticks, each after a reset
        for (int p = 1; p < 4; p++) begin
            per_ticks = (p == 1) ? 16 : ((p == 2) ? 128 : 1024);
            @(posedge core_clk);
            rstn <= 1'b0;
            repeat (3) @(posedge core_clk);
            rstn <= 1'b1;
            apb(1'b1, WTW_CTRL_OFF, {26'h0, 2'h3, WTW_LP_KEEP, p[1:0]});
            ticks(per_ticks - 1);
            apb(1'b0, WTW_STAT_OFF, 32'h0);
            chk("count before period", 32'h0, rd);
            ticks(1);
            apb(1'b0, WTW_STAT_OFF, 32'h0);
            chk("count at period", 32'h1, rd);
        end
        $display("period code test done");
        end_sim();
    end
endmodule : test_watchdog_with_time_wheel
